// File: inc/cfg_pkg.sv
// constants, types and factory bank images for the configuration front end
// Function
// - strap sampled once at power-up, held
// - strap high: pins select one of four banks
// - strap low: pins become serial target port
// - no register access in hardware-select mode
// - copy chosen bank into RAM, run from RAM
// - host rewrites RAM; new contents drive outputs
// - register 0 low field picks power-up bank
// - host command reloads RAM from another bank
// - writing a new value to load field loads that bank
// - target address 0x68 plus register 0 field
// - block transfers: address, then start pointer
// - pointer advances per byte, msb first
// - transfer may end after any byte
// - buffered write bytes committed together at stop
// - register 1 upper bit enables reference output
// - register 1 bit 4: low or high impedance
// - register 1 bits 3..2 reference supply level
// - register 5 bit 7 enables output one
// - register 5 bits 6..4 output one format
// - register 5 bits 3..2 output one supply
package cfg_pkg;
  localparam int NUM_REGS = 6;
  localparam int NUM_BANKS = 4;
  localparam int IMG_W = NUM_REGS * 8;
  // register offsets
  localparam logic [7:0] OFS_BUS = 8'h00;
  localparam logic [7:0] OFS_REF = 8'h01;
  localparam logic [7:0] OFS_RSV_A = 8'h02;
  localparam logic [7:0] OFS_RSV_B = 8'h03;
  localparam logic [7:0] OFS_RSV_C = 8'h04;
  localparam logic [7:0] OFS_CLOCK_OUTPUT_ONE = 8'h05;
  // field positions
  localparam int BUS_ADDR_LSB = 5;
  localparam int BUS_BANK_LSB = 0;
  localparam int REF_EN_BIT = 7;
  localparam int REF_HIZ_BIT = 4;
  localparam int REF_SUP_LSB = 2;
  localparam int CLOCK_OUTPUT_ONE_EN_BIT = 7;
  localparam int CLOCK_OUTPUT_ONE_FMT_LSB = 4;
  localparam int CLOCK_OUTPUT_ONE_SUP_LSB = 2;
  // base 7-bit target address
  localparam logic [6:0] BASE_ADDR = 7'h68;
  // reset values
  localparam logic [7:0] RST_BUS = 8'h00;
  localparam logic [7:0] RST_REF = 8'hCF;
  localparam logic [7:0] RST_RSV_A = 8'h8F;
  localparam logic [7:0] RST_RSV_B = 8'h01;
  localparam logic [7:0] RST_RSV_C = 8'h44;
  localparam logic [7:0] RST_CLOCK_OUTPUT_ONE = 8'h8F;
  // host-writable bits per register, index 5 down to 0
  localparam logic [IMG_W-1:0] WR_MASK = 48'hFC_00_00_00_DC_63;
  // reset cycles allowed for the strap and pin synchronisers to fill
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;
  typedef logic [IMG_W-1:0] image_t;
  // factory bank images, byte i at bits 8*i+7..8*i
  localparam image_t OTP_BANK [NUM_BANKS] = '{
    {RST_CLOCK_OUTPUT_ONE, RST_RSV_C, RST_RSV_B, RST_RSV_A, RST_REF, RST_BUS},
    {8'hBB, RST_RSV_C, RST_RSV_B, RST_RSV_A, 8'hCB, 8'h81},
    {8'hDF, RST_RSV_C, RST_RSV_B, RST_RSV_A, 8'h5F, 8'h82},
    {8'hF7, RST_RSV_C, RST_RSV_B, RST_RSV_A, 8'hD7, 8'h83}};
  // supply level decode
  typedef enum logic [1:0] {
    SUP_1V8 = 2'h0, SUP_2V5 = 2'h1, SUP_3V3 = 2'h2
  } supply_t;
  // output one signalling formats
  typedef enum logic [2:0] {
    FMT_LOW_POWER_HCSL_FORMAT = 3'h0, FMT_SE_TRUE = 3'h1, FMT_UNUSED_A = 3'h2,
    FMT_LVDS = 3'h3, FMT_SE_COMP = 3'h4, FMT_DIFF_CMOS = 3'h5,
    FMT_UNUSED_B = 3'h6, FMT_DUAL_PHASE = 3'h7
  } fmt_t;
  typedef struct packed {
    logic enable;
    logic hiz_when_off;
    supply_t supply;
  } ref_ctrl_t;
  typedef struct packed {
    logic enable;
    fmt_t format;
    logic format_valid;
    supply_t supply;
  } clock_output_one_ctrl_t;
  // bank loader states
  typedef enum logic [3:0] {
    LD_SETTLE = 4'h1, LD_STRAP = 4'h2, LD_COPY = 4'h4, LD_RUN = 4'h8
  } ld_t;
  // serial transfer phases
  typedef enum logic [5:0] {
    PH_IDLE = 6'h01, PH_DEV = 6'h02, PH_PTR = 6'h04,
    PH_WR = 6'h08, PH_RD = 6'h10, PH_SKIP = 6'h20
  } phase_t;
  // link-side state, clocked by the serial clock
  typedef struct packed {
    logic bit_val;
    logic tgl;
  } link_t;
  // system-side state
  typedef struct packed {
    logic [1:0] rst_cnt;
    ld_t ld;
    logic bus_mode;
    logic [1:0] bank;
    image_t regs;
    image_t wbuf;
    logic [NUM_REGS-1:0] wvalid;
    phase_t ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic ack_slot;
    logic sda_oe;
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [1:0] strap_s;
    logic [1:0] tgl_s;
    logic scl_p;
    logic sda_p;
    logic tgl_p;
  } sys_t;
endpackage : cfg_pkg

// File: rtl/clockgen_cfg.sv
// configuration front end: strap, bank loader, serial target, RAM registers
`timescale 1ns/10ps
`default_nettype none
module clockgen_cfg (
  input wire logic clk_i,                  // system clock, 250 MHz
  input wire logic rst_b_i,                // power-up reset, active low
  input wire logic mode_strap_pin_i,       // high: hardware select mode
  input wire logic scl_i,                  // serial clock / bank_select_low
  input wire logic sda_i,                  // serial data / bank_select_high
  output logic sda_o,                      // serial data drive level
  output logic sda_oe_o,                   // serial data drive enable
  output logic bus_mode_o,                 // latched mode: serial bus
  output logic cfg_ready_o,                // bank copy done, running
  output logic [1:0] loaded_bank_o,        // last bank copied to RAM
  output cfg_pkg::ref_ctrl_t ref_ctrl_o,   // reference output controls
  output cfg_pkg::clock_output_one_ctrl_t clock_output_one_ctrl_o  // output one controls
);

  // supply level code to level
  function automatic cfg_pkg::supply_t supply_dec(input logic [1:0] code);
    cfg_pkg::supply_t lvl;
    case (code)
      2'h2: lvl = cfg_pkg::SUP_2V5;
      2'h3: lvl = cfg_pkg::SUP_3V3;
      default: lvl = cfg_pkg::SUP_1V8;
    endcase
    return lvl;
  endfunction : supply_dec

  // one byte of the register image
  function automatic logic [7:0] reg_byte(input cfg_pkg::image_t img,
                                          input logic [7:0] ofs);
    logic [7:0] b;
    b = 8'h00;
    if (ofs < 8'(cfg_pkg::NUM_REGS)) begin
      b = img[ofs[2:0]*8 +: 8];
    end
    return b;
  endfunction : reg_byte

  // reset synchroniser: asserts at once, releases after two edges
  logic [1:0] rst_sync_q;
  logic rst_b;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  // link domain: sample data on each rising serial clock, toggle per edge
  cfg_pkg::link_t lnk_q, lnk_d;
  always_comb begin
    lnk_d = lnk_q;
    lnk_d.bit_val = sda_i;
    lnk_d.tgl = ~lnk_q.tgl;
  end

  // link register, on the serial clock's own edges
  always_ff @(posedge scl_i or negedge rst_b) begin
    if (!rst_b) begin
      lnk_q <= '0;
    end else begin
      lnk_q <= lnk_d;
    end
  end

  // system state
  cfg_pkg::sys_t q, d;

  // event decode from synchronised pins
  logic scl_hi;      // synchronised clock level
  logic sda_hi;      // synchronised data level
  logic ev_start;    // data falls while clock high
  logic ev_stop;     // data rises while clock high
  logic ev_rise;     // link sampled a bit
  logic ev_fall;     // clock fell
  logic active;      // serial port live
  logic [6:0] my_addr;
  cfg_pkg::image_t next_regs;
  logic [7:0] rd_byte;

  always_comb begin
    scl_hi = q.scl_s[1];
    sda_hi = q.sda_s[1];
    ev_start = scl_hi && q.scl_p && q.sda_p && !sda_hi;
    ev_stop = scl_hi && q.scl_p && !q.sda_p && sda_hi;
    ev_rise = q.tgl_s[1] != q.tgl_p;
    ev_fall = q.scl_p && !scl_hi;
    active = q.bus_mode && (q.ld == cfg_pkg::LD_RUN);
    my_addr = cfg_pkg::BASE_ADDR |
              7'(q.regs[cfg_pkg::BUS_ADDR_LSB +: 2]);
    rd_byte = reg_byte(q.regs, q.ptr);
  end

  // commit of buffered write bytes, masked against reserved bits
  always_comb begin
    next_regs = q.regs;
    for (int i = 0; i < cfg_pkg::NUM_REGS; i++) begin
      if (q.wvalid[i]) begin
        next_regs[i*8 +: 8] = (q.regs[i*8 +: 8] & ~cfg_pkg::WR_MASK[i*8 +: 8])
          | (q.wbuf[i*8 +: 8] & cfg_pkg::WR_MASK[i*8 +: 8]);
      end
    end
  end

  // next-state logic
  always_comb begin
    d = q;
    // pin synchronisers, first stage read only by the second
    d.scl_s = {q.scl_s[0], scl_i};
    d.sda_s = {q.sda_s[0], sda_i};
    d.strap_s = {q.strap_s[0], mode_strap_pin_i};
    d.tgl_s = {q.tgl_s[0], lnk_q.tgl};
    d.scl_p = q.scl_s[1];
    d.sda_p = q.sda_s[1];
    d.tgl_p = q.tgl_s[1];

    // bank loader
    case (q.ld)
      cfg_pkg::LD_SETTLE: begin
        // let the synchronisers fill before the strap is taken
        d.rst_cnt = q.rst_cnt + 2'h1;
        if (q.rst_cnt == cfg_pkg::SETTLE_CYCLES) begin
          d.ld = cfg_pkg::LD_STRAP;
        end
      end
      cfg_pkg::LD_STRAP: begin
        // strap taken once and held for the session
        d.bus_mode = !q.strap_s[1];
        if (q.strap_s[1]) begin
          d.bank = {q.sda_s[1], q.scl_s[1]};
        end else begin
          d.bank = cfg_pkg::OTP_BANK[0][cfg_pkg::BUS_BANK_LSB +: 2];
        end
        d.ld = cfg_pkg::LD_COPY;
      end
      cfg_pkg::LD_COPY: begin
        // whole bank lands in RAM at once
        d.regs = cfg_pkg::OTP_BANK[q.bank];
        d.regs[cfg_pkg::BUS_BANK_LSB +: 2] = q.bank;
        d.ld = cfg_pkg::LD_RUN;
      end
      cfg_pkg::LD_RUN: begin
        d.ld = cfg_pkg::LD_RUN;
      end
      default: begin
        d.ld = cfg_pkg::LD_SETTLE;
      end
    endcase

    // serial target
    if (!active) begin
      // hardware select mode or loader not yet in run: never drive, never respond
      d.ph = cfg_pkg::PH_IDLE;
      d.sda_oe = 1'b0;
      d.wvalid = '0;
    end else if (ev_stop) begin
      // stop: commit all buffered bytes in one update
      d.regs = next_regs;
      if (q.wvalid[0] && (next_regs[cfg_pkg::BUS_BANK_LSB +: 2] !=
          q.regs[cfg_pkg::BUS_BANK_LSB +: 2])) begin
        d.bank = next_regs[cfg_pkg::BUS_BANK_LSB +: 2];
        d.ld = cfg_pkg::LD_COPY;
      end
      d.wvalid = '0;
      d.ph = cfg_pkg::PH_IDLE;
      d.sda_oe = 1'b0;
      d.ack_slot = 1'b0;
    end else if (ev_start) begin
      // start or repeated start: buffered bytes wait for stop
      d.ph = cfg_pkg::PH_DEV;
      d.bitn = 4'h0;
      d.ack_slot = 1'b0;
      d.sda_oe = 1'b0;
    end else if (ev_rise) begin
      if (q.ack_slot) begin
        // host's answer to a read byte; high means last byte
        if ((q.ph == cfg_pkg::PH_RD) && lnk_q.bit_val) begin
          d.ph = cfg_pkg::PH_SKIP;
        end
      end else if (q.bitn != 4'h8) begin
        // msb arrives first
        d.sh = {q.sh[6:0], lnk_q.bit_val};
        d.bitn = q.bitn + 4'h1;
      end
    end else if (ev_fall) begin
      if (q.ack_slot) begin
        // end of acknowledge clock
        d.ack_slot = 1'b0;
        d.bitn = 4'h0;
        d.sda_oe = 1'b0;
        if (q.ph == cfg_pkg::PH_RD) begin
          // present next byte from the pointer
          d.sh = rd_byte;
          d.ptr = q.ptr + 8'h01;
          d.sda_oe = !rd_byte[7];
        end
      end else if (q.bitn == 4'h8) begin
        // whole byte seen: decide and acknowledge
        d.ack_slot = 1'b1;
        d.sda_oe = 1'b0;
        case (q.ph)
          cfg_pkg::PH_DEV: begin
            if (q.sh[7:1] == my_addr) begin
              d.sda_oe = 1'b1;
              d.ph = q.sh[0] ? cfg_pkg::PH_RD : cfg_pkg::PH_PTR;
            end else begin
              d.ph = cfg_pkg::PH_SKIP;
            end
          end
          cfg_pkg::PH_PTR: begin
            // start address sets the first register
            d.ptr = q.sh;
            d.sda_oe = 1'b1;
            d.ph = cfg_pkg::PH_WR;
          end
          cfg_pkg::PH_WR: begin
            // held in the buffer until stop
            if (q.ptr < 8'(cfg_pkg::NUM_REGS)) begin
              d.wbuf[q.ptr[2:0]*8 +: 8] = q.sh;
              d.wvalid[q.ptr[2:0]] = 1'b1;
            end
            d.ptr = q.ptr + 8'h01;
            d.sda_oe = 1'b1;
          end
          cfg_pkg::PH_RD: begin
            // host acknowledges; line released
            d.sda_oe = 1'b0;
          end
          default: begin
            d.sda_oe = 1'b0;
          end
        endcase
      end else if (q.ph == cfg_pkg::PH_RD) begin
        // next read bit, msb first
        d.sda_oe = !q.sh[7];
      end
    end
  end

  // single state register
  always_ff @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      q <= '{rst_cnt: 2'h0, ld: cfg_pkg::LD_SETTLE, bus_mode: 1'b0,
             bank: 2'h0, regs: cfg_pkg::OTP_BANK[0], wbuf: '0,
             wvalid: '0, ph: cfg_pkg::PH_IDLE, bitn: 4'h0, sh: 8'h00,
             ptr: 8'h00, ack_slot: 1'b0, sda_oe: 1'b0, scl_s: 2'h0,
             sda_s: 2'h0, strap_s: 2'h0, tgl_s: 2'h0, scl_p: 1'b0,
             sda_p: 1'b0, tgl_p: 1'b0};
    end else begin
      q <= d;
    end
  end

  // outputs decoded from RAM registers
  logic [7:0] ref_reg;
  logic [7:0] clock_output_one_reg;
  logic [2:0] fmt_code;
  always_comb begin
    ref_reg = q.regs[cfg_pkg::OFS_REF[2:0]*8 +: 8];
    clock_output_one_reg = q.regs[cfg_pkg::OFS_CLOCK_OUTPUT_ONE[2:0]*8 +: 8];
    fmt_code = clock_output_one_reg[cfg_pkg::CLOCK_OUTPUT_ONE_FMT_LSB +: 3];
    ref_ctrl_o.enable = ref_reg[cfg_pkg::REF_EN_BIT];
    ref_ctrl_o.hiz_when_off = ref_reg[cfg_pkg::REF_HIZ_BIT];
    ref_ctrl_o.supply =
      supply_dec(ref_reg[cfg_pkg::REF_SUP_LSB +: 2]);
    clock_output_one_ctrl_o.enable = clock_output_one_reg[cfg_pkg::CLOCK_OUTPUT_ONE_EN_BIT];
    clock_output_one_ctrl_o.format = cfg_pkg::fmt_t'(fmt_code);
    clock_output_one_ctrl_o.format_valid =
      (fmt_code != cfg_pkg::FMT_UNUSED_A) &&
      (fmt_code != cfg_pkg::FMT_UNUSED_B);
    clock_output_one_ctrl_o.supply =
      supply_dec(clock_output_one_reg[cfg_pkg::CLOCK_OUTPUT_ONE_SUP_LSB +: 2]);
  end

  // pin and status outputs
  assign sda_o = 1'b0;
  assign sda_oe_o = q.sda_oe;
  assign bus_mode_o = q.bus_mode;
  assign cfg_ready_o = q.ld == cfg_pkg::LD_RUN;
  assign loaded_bank_o = q.bank;

endmodule : clockgen_cfg
`default_nettype wire

// File: tb/i2c_host_model.sv
// serial host model standing on the far side of the shared pins
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
  parameter int HALF_NS = 120 // scl phase length, above the 100 ns minimum
) (
  input wire logic dev_oe_i, // device pulls the data line low
  output logic scl_o, // serial clock, high and still between frames
  output logic sda_o // wired data line level, pulled up when released
);
  logic sda_h; // host release of the data line
  // open drain: either party can pull low, the pull-up wins otherwise
  assign sda_o = sda_h & ~dev_oe_i;
  initial begin
    scl_o = 1'b1;
    sda_h = 1'b1;
  end
  // start, or repeated start from a low clock
  task automatic start;
    sda_h = 1'b1;
    #(HALF_NS) scl_o = 1'b1;
    #(HALF_NS) sda_h = 1'b0;
    #(HALF_NS) scl_o = 1'b0;
  endtask : start
  // stop after any whole byte
  task automatic stop;
    sda_h = 1'b0;
    #(HALF_NS) scl_o = 1'b1;
    #(HALF_NS) sda_h = 1'b1;
    #(HALF_NS);
  endtask : stop
  // data set while clock low, line sampled just before the rising edge
  task automatic xbit(input logic b, output logic s);
    sda_h = b;
    #(HALF_NS) s = sda_o;
    scl_o = 1'b1;
    #(HALF_NS) scl_o = 1'b0;
  endtask : xbit
  // eight bits msb first, then the acknowledge slot driven with last
  task automatic xbyte(input logic [7:0] w, input logic last,
                       output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) xbit(w[i], r[i]);
    xbit(last, ack);
  endtask : xbyte
endmodule : i2c_host_model
`default_nettype wire

// File: tb/clockgen_cfg_props.sv
// port-level checks of the configuration front end
`timescale 1ns/10ps
`default_nettype none
module clockgen_cfg_props (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic mode_strap_pin_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic bus_mode_o,
  input wire logic cfg_ready_o,
  input wire logic [1:0] loaded_bank_o,
  input wire cfg_pkg::ref_ctrl_t ref_ctrl_o,
  input wire cfg_pkg::clock_output_one_ctrl_t clock_output_one_ctrl_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic seen_q; // loader has finished once since reset
  // marks the first power-up copy apart from later reloads
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      seen_q <= 1'b0;
    end else if (cfg_ready_o) begin
      seen_q <= 1'b1;
    end
  end
  // first completion of the power-up copy
  sequence s_boot_done;
    $rose(cfg_ready_o) && !seen_q;
  endsequence
  // running steadily for some cycles
  sequence s_running;
    cfg_ready_o && $past(cfg_ready_o) && $past(cfg_ready_o, 3);
  endsequence
  property p_mode_held;
    s_running |-> $stable(bus_mode_o);
  endproperty
  a_mode_held: assert property (p_mode_held) else $error("mode moved");
  property p_strap_mode;
    s_boot_done |-> bus_mode_o == !mode_strap_pin_i;
  endproperty
  a_strap_mode: assert property (p_strap_mode) else $error("bad mode");
  property p_hw_bank;
    s_boot_done ##0 !bus_mode_o |=> loaded_bank_o == {sda_i, scl_i};
  endproperty
  a_hw_bank: assert property (p_hw_bank) else $error("bad bank");
  property p_bus_bank;
    s_boot_done ##0 bus_mode_o |=> loaded_bank_o == 2'h0;
  endproperty
  a_bus_bank: assert property (p_bus_bank) else $error("boot bank");
  property p_no_drive_hw;
    !bus_mode_o |-> !sda_oe_o;
  endproperty
  a_no_drive_hw: assert property (p_no_drive_hw) else $error("drove");
  property p_drive_on_low;
    $rose(sda_oe_o) |-> !scl_i && !sda_o && bus_mode_o;
  endproperty
  a_drive_on_low: assert property (p_drive_on_low) else $error("edge");
  property p_commit_at_stop;
    s_running ##0 (!$stable(ref_ctrl_o) || !$stable(clock_output_one_ctrl_o))
      |-> scl_i && sda_i;
  endproperty
  a_commit_at_stop: assert property (p_commit_at_stop) else $error("early");
  property p_fmt_valid;
    clock_output_one_ctrl_o.format_valid == (clock_output_one_ctrl_o.format != cfg_pkg::FMT_UNUSED_A
      && clock_output_one_ctrl_o.format != cfg_pkg::FMT_UNUSED_B);
  endproperty
  a_fmt_valid: assert property (p_fmt_valid) else $error("format flag");
  property p_supply_code;
    ref_ctrl_o.supply != 2'h3 && clock_output_one_ctrl_o.supply != 2'h3;
  endproperty
  a_supply_code: assert property (p_supply_code) else $error("supply");
endmodule : clockgen_cfg_props
bind clockgen_cfg clockgen_cfg_props clockgen_cfg_props_inst (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .mode_strap_pin_i(mode_strap_pin_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .bus_mode_o(bus_mode_o), .cfg_ready_o(cfg_ready_o),
  .loaded_bank_o(loaded_bank_o), .ref_ctrl_o(ref_ctrl_o),
  .clock_output_one_ctrl_o(clock_output_one_ctrl_o));
`default_nettype wire

// File: tb/clockgen_cfg_bench.sv
// self-checking bench for the configuration front end
`timescale 1ns/10ps
`default_nettype none
module clockgen_cfg_bench;
  logic clk_i, rst_b_i, strap; // clock, reset, mode strap
  logic pin_hw; // select straps own the shared pins
  logic [1:0] sel_v; // select strap levels
  logic sda_o, sda_oe_o, bus_mode_o, cfg_ready_o;
  logic [1:0] loaded_bank_o;
  cfg_pkg::ref_ctrl_t ref_ctrl_o;
  cfg_pkg::clock_output_one_ctrl_t clock_output_one_ctrl_o;
  logic host_scl, line_sda, scl_pin, sda_pin; // host side and pin levels
  logic [7:0] v; // byte under test
  int fail_count, total_checks;
  logic [7:0] ref_img [4] = '{8'hCF, 8'hCB, 8'h5F, 8'hD7}; // bank byte 1
  logic [7:0] out_img [4] = '{8'h8F, 8'hBB, 8'hDF, 8'hF7}; // bank byte 5
  assign scl_pin = pin_hw ? sel_v[0] : host_scl;
  assign sda_pin = pin_hw ? sel_v[1] : line_sda;
  clockgen_cfg clockgen_cfg_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .mode_strap_pin_i(strap), .scl_i(scl_pin), .sda_i(sda_pin),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .bus_mode_o(bus_mode_o),
    .cfg_ready_o(cfg_ready_o), .loaded_bank_o(loaded_bank_o),
    .ref_ctrl_o(ref_ctrl_o), .clock_output_one_ctrl_o(clock_output_one_ctrl_o));
  i2c_host_model i2c_host_model_inst (.dev_oe_i(sda_oe_o),
    .scl_o(host_scl), .sda_o(line_sda));
  // supply code to level
  function automatic logic [1:0] sup(input logic [1:0] c);
    return c[1] ? (c[0] ? 2'h2 : 2'h1) : 2'h0;
  endfunction : sup
  function automatic logic [7:0] ref_exp(input logic [7:0] r);
    return {4'h0, r[7], r[4], sup(r[3:2])};
  endfunction : ref_exp
  function automatic logic [7:0] out_exp(input logic [7:0] r);
    return {1'h0, r[7], r[6:4], r[6:4] != 3'h2 && r[6:4] != 3'h6,
            sup(r[3:2])};
  endfunction : out_exp
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // reset with given strap and selects, wait for the copy to finish
  task automatic power_up(input logic s, input logic [1:0] sel);
    @(negedge clk_i);
    rst_b_i = 1'b0;
    strap = s;
    pin_hw = s;
    sel_v = sel;
    repeat (16) @(negedge clk_i);
    rst_b_i = 1'b1;
    for (int i = 0; i < 100 && cfg_ready_o !== 1'b1; i++) @(negedge clk_i);
    if (cfg_ready_o !== 1'b1) begin
      fail_count++;
      summarize();
    end
  endtask : power_up
  // one byte out, acknowledge slot compared
  task automatic put(input logic [7:0] b, input logic nack);
    logic [7:0] r;
    logic k;
    i2c_host_model_inst.xbyte(b, 1'b1, r, k);
    chk("ack", {7'h0, k}, {7'h0, nack});
  endtask : put
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    i2c_host_model_inst.start();
    put({a, 1'b0}, 1'b0);
    put(p, 1'b0);
    put(d, 1'b0);
    i2c_host_model_inst.stop();
    repeat (20) @(negedge clk_i);
  endtask : wr
  // pointed or current read of n bytes, expected bytes high first
  task automatic rd(input logic [6:0] a, input logic [7:0] p, input logic cur,
                    input int n, input logic [15:0] e);
    logic [7:0] r;
    logic k;
    i2c_host_model_inst.start();
    if (!cur) begin
      put({a, 1'b0}, 1'b0);
      put(p, 1'b0);
      i2c_host_model_inst.start();
    end
    put({a, 1'b1}, 1'b0);
    for (int i = 0; i < n; i++) begin
      i2c_host_model_inst.xbyte(8'hFF, i == n - 1, r, k);
      chk("read", r, e[15-8*i -: 8]);
    end
    i2c_host_model_inst.stop();
  endtask : rd
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // hang guard
  initial begin
    #390000;
    fail_count++;
    summarize();
  end
  initial begin
    rst_b_i = 1'b0;
    strap = 1'b1;
    pin_hw = 1'b1;
    sel_v = 2'h0;
    for (int b = 0; b < 4; b++) begin
      power_up(1'b1, b[1:0]);
      chk("bank", {6'h0, loaded_bank_o}, b[7:0]);
      chk("mode", {7'h0, bus_mode_o}, 8'h00);
      chk("ref", {4'h0, ref_ctrl_o}, ref_exp(ref_img[b]));
      chk("clock_output_one", {1'h0, clock_output_one_ctrl_o}, out_exp(out_img[b]));
    end
    pin_hw = 1'b0;
    i2c_host_model_inst.start();
    put({7'h68, 1'b0}, 1'b1);
    i2c_host_model_inst.stop();
    chk("ref", {4'h0, ref_ctrl_o}, ref_exp(ref_img[3]));
    $display("test hw_select done");
    power_up(1'b0, 2'h0);
    chk("mode", {7'h0, bus_mode_o}, 8'h01);
    chk("bank", {6'h0, loaded_bank_o}, 8'h00);
    i2c_host_model_inst.start();
    put({7'h68, 1'b0}, 1'b0);
    put(8'h01, 1'b0);
    put(8'h10, 1'b0);
    put(8'hFF, 1'b0);
    repeat (20) @(negedge clk_i);
    chk("ref", {4'h0, ref_ctrl_o}, ref_exp(8'hCF));
    chk("sda_level", {7'h0, sda_o}, 8'h00);
    i2c_host_model_inst.stop();
    repeat (20) @(negedge clk_i);
    chk("ref", {4'h0, ref_ctrl_o}, ref_exp(8'h13));
    rd(7'h68, 8'h01, 1'b0, 2, 16'h138F);
    rd(7'h68, 8'h00, 1'b1, 1, 16'h0100);
    $display("test block_write done");
    for (int c = 0; c < 8; c++) begin
      v = {c[0], c[2:0], 2'h2, 2'h3};
      wr(7'h68, 8'h05, v);
      chk("clock_output_one", {1'h0, clock_output_one_ctrl_o}, out_exp(v));
    end
    $display("test formats done");
    wr(7'h68, 8'h00, 8'h03);
    chk("bank", {6'h0, loaded_bank_o}, 8'h03);
    chk("ref", {4'h0, ref_ctrl_o}, ref_exp(8'hD7));
    rd(7'h68, 8'h00, 1'b0, 1, 16'h8300);
    wr(7'h68, 8'h00, 8'h23);
    i2c_host_model_inst.start();
    put({7'h68, 1'b0}, 1'b1);
    i2c_host_model_inst.stop();
    rd(7'h69, 8'h00, 1'b0, 1, 16'hA300);
    $display("test reload_address done");
    summarize();
  end
endmodule : clockgen_cfg_bench
`default_nettype wire
